//--- hdl/mcd_host.sv
// host end: AXI4-Lite driven issuer of download commands
`timescale 1ns/1ps
`default_nettype none
module mcd_host (
  input wire logic aclk,
  input wire logic aresetn,
  mcd_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import mcd_pkg::*;

  // ===========================================================
  // write channel capture: address and data in either order
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_reg;
  logic [31:0] w_reg;
  logic busy_reg;
  logic [31:0] task_reg;
  logic [15:0] offset_reg;
  logic [7:0] err_seen_reg;
  logic [7:0] cond_seen_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;

  wire logic wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid &&
    !(aw_reg == OFS_DATA && link.data_valid);
  wire logic rd_go = s_axi_arvalid && s_axi_arready;
  wire logic mapped = aw_reg == OFS_CTRL || aw_reg == OFS_TASK ||
    aw_reg == OFS_OFFSET || aw_reg == OFS_DATA || aw_reg == OFS_IRQ_MASK;
  wire logic stat_rd = rd_go && s_axi_araddr == OFS_IRQ_STAT;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_reg <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ===========================================================
  // read channel: one read in flight, unmapped answers SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_go)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          OFS_TASK: s_axi_rdata <= task_reg;
          OFS_OFFSET: s_axi_rdata <= {16'h0000, offset_reg};
          OFS_RESULT:
            s_axi_rdata <= {15'h0000, busy_reg, cond_seen_reg, err_seen_reg};
          OFS_IRQ_STAT: s_axi_rdata <= {30'h00000000, irq_stat_reg};
          OFS_IRQ_MASK: s_axi_rdata <= {30'h00000000, irq_mask_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ===========================================================
  // task file drive; go is ignored while a command is open
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      task_reg <= 32'h00000000;
      offset_reg <= 16'h0000;
      busy_reg <= 1'b0;
      irq_mask_reg <= 2'b00;
      link.cmd_valid <= 1'b0;
      link.cmd_opcode <= 8'h00;
      link.cmd_feature <= 8'h00;
      link.cmd_count <= 8'h00;
      link.cmd_lba_low <= 8'h00;
      link.cmd_lba_mid <= 8'h00;
      link.cmd_lba_high <= 8'h00;
      link.soft_reset <= 1'b0;
      link.data_valid <= 1'b0;
      link.data <= 32'h00000000;
    end
    else
    begin
      link.cmd_valid <= 1'b0;
      link.soft_reset <= 1'b0;
      if (link.data_valid && link.data_ready)
        link.data_valid <= 1'b0;
      if (link.done)
        busy_reg <= 1'b0;
      if (wr_go)
      begin
        case (aw_reg)
          OFS_TASK: task_reg <= w_reg;
          OFS_OFFSET: offset_reg <= w_reg[15:0];
          OFS_IRQ_MASK: irq_mask_reg <= w_reg[1:0];
          OFS_DATA:
          begin
            link.data_valid <= 1'b1;
            link.data <= w_reg;
          end
          OFS_CTRL:
          begin
            if (w_reg[1])
            begin
              // soft reset abandons the command and any queued word
              link.soft_reset <= 1'b1;
              link.data_valid <= 1'b0;
              busy_reg <= 1'b0;
            end
            else if (w_reg[0] && !busy_reg)
            begin
              busy_reg <= 1'b1;
              link.cmd_valid <= 1'b1;
              link.cmd_opcode <= task_reg[7:0];
              link.cmd_feature <= task_reg[15:8];
              link.cmd_count <= task_reg[23:16];
              link.cmd_lba_low <= task_reg[31:24];
              link.cmd_lba_mid <= offset_reg[7:0];
              link.cmd_lba_high <= offset_reg[15:8];
            end
          end
          default: busy_reg <= busy_reg;
        endcase
      end
    end
  end

  // ===========================================================
  // completion capture and sticky events; a new event beats the read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_seen_reg <= ERR_RESET;
      cond_seen_reg <= COND_RESET;
      irq_stat_reg <= 2'b00;
      irq <= 1'b0;
    end
    else
    begin
      if (link.done)
      begin
        err_seen_reg <= link.error_flags;
        cond_seen_reg <= link.condition_flags;
      end
      irq_stat_reg[IRQ_DONE] <= link.done ||
        (irq_stat_reg[IRQ_DONE] && !stat_rd);
      irq_stat_reg[IRQ_FAIL] <= (link.done && link.condition_flags[ST_ERR])
        || (irq_stat_reg[IRQ_FAIL] && !stat_rd);
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : mcd_host
`default_nettype wire

//--- hdl/mcd_pkg.sv
// shared constants for the firmware download command path
package mcd_pkg;
  // ===========================================================
  // task-file codes
  localparam logic [7:0] OPC_DOWNLOAD = 8'h92;
  localparam logic [7:0] SUB_OFFSETS = 8'h03;
  localparam logic [7:0] SUB_SINGLE = 8'h07;
  // ===========================================================
  // error and condition flag positions
  localparam int ERR_UNC = 6;
  localparam int ERR_ABT = 2;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [7:0] COND_RESET = 8'h50;
  // ===========================================================
  // sizes: a sector is 512 bytes, 128 words of 32 bits
  localparam int SECTOR_BYTES = 512;
  localparam int WORD_BYTES = 4;
  localparam int SECTOR_WORDS = SECTOR_BYTES / WORD_BYTES;
  localparam int WORD_SHIFT = 7;
  localparam logic [15:0] IMAGE_SECTORS_RESET = 16'h0000;
  // ===========================================================
  // host-side AXI4-Lite register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TASK = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ===========================================================
  // device states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_COMMIT = 2'b10
  } mcd_state_t;
endpackage : mcd_pkg

//--- hdl/mcd_if.sv
// task-file link between host controller and drive
`timescale 1ns/1ps
`default_nettype none
interface mcd_if;
  logic cmd_valid;
  logic [7:0] cmd_opcode;
  logic [7:0] cmd_feature;
  logic [7:0] cmd_count;
  logic [7:0] cmd_lba_low;
  logic [7:0] cmd_lba_mid;
  logic [7:0] cmd_lba_high;
  logic soft_reset;
  logic data_valid;
  logic [31:0] data;
  logic data_ready;
  logic done;
  logic [7:0] error_flags;
  logic [7:0] condition_flags;
  modport host (
    output cmd_valid, cmd_opcode, cmd_feature, cmd_count, cmd_lba_low,
    output cmd_lba_mid, cmd_lba_high, soft_reset, data_valid, data,
    input data_ready, done, error_flags, condition_flags
  );
  modport device (
    input cmd_valid, cmd_opcode, cmd_feature, cmd_count, cmd_lba_low,
    input cmd_lba_mid, cmd_lba_high, soft_reset, data_valid, data,
    output data_ready, done, error_flags, condition_flags
  );
endinterface : mcd_if
`default_nettype wire

//--- hdl/mcd_device.sv
// drive end: firmware download command interpreter
// Overview of operation
// - opcode 92h selects firmware download
// - feature 03h segmented, 07h single-shot
// - length = lba low high byte, count low
// - host sends whole sectors only
// - abort on reserved subcommand or lock
// - failed requested reload flags uncorrectable
// - spin down after reload if spin-up off
// - segment offset from lba high and mid
// - host sends segments in ascending order
// - offset mismatch aborts and discards image
// - first segment offset must be zero
// - last segment: verify and save image
// - activate new code right after transfer (code commits, waits commit_done, then reloads only if reload_req)
// - other command executes, discards segments
// - reset drops segments before processing
`timescale 1ns/1ps
`default_nettype none
module mcd_device (
  input wire logic aclk,
  input wire logic aresetn,
  mcd_if.device link,
  input wire logic security_locked,
  input wire logic spinup_disabled,
  input wire logic [15:0] image_sectors,
  output logic img_we,
  output logic [22:0] img_addr,
  output logic [31:0] img_data,
  output logic discard,
  output logic commit,
  input wire logic commit_done,
  input wire logic reload_req,
  input wire logic reload_ok,
  output logic spin_down,
  output logic other_cmd,
  output logic [7:0] other_opcode
);
  import mcd_pkg::*;

  // ===========================================================
  // state
  mcd_state_t state_reg;
  logic seq_active_reg;
  logic [15:0] expect_reg;
  logic [15:0] seg_end_reg;
  logic last_seg_reg;
  logic [22:0] words_left_reg;
  logic [7:0] err_reg;
  logic [7:0] cond_reg;

  wire logic [15:0] req_len = {link.cmd_lba_low, link.cmd_count};
  wire logic [15:0] req_ofs = {link.cmd_lba_high, link.cmd_lba_mid};
  wire logic is_dl = link.cmd_opcode == OPC_DOWNLOAD;
  wire logic sub_ok = link.cmd_feature == SUB_OFFSETS ||
    link.cmd_feature == SUB_SINGLE;
  wire logic seg_mode = link.cmd_feature == SUB_OFFSETS;
  // a fresh sequence must start at zero, a running one where it stopped
  wire logic [15:0] want_ofs = seq_active_reg ? expect_reg : 16'h0000;
  wire logic take = link.cmd_valid && state_reg == ST_IDLE;
  wire logic beat = link.data_valid && link.data_ready;

  // sectors to words; the image address space covers 16-bit offsets
  function automatic logic [22:0] to_words(input logic [15:0] sectors);
    to_words = {sectors, 7'h00};
  endfunction : to_words

  // completion flags with busy dropped
  function automatic logic [7:0] finish(input logic [7:0] err);
    logic [7:0] c;
    c = 8'h00;
    c[ST_RDY] = 1'b1;
    c[ST_DSC] = 1'b1;
    c[ST_ERR] = |err;
    finish = c;
  endfunction : finish

  assign link.error_flags = err_reg;
  assign link.condition_flags = cond_reg;

  // ===========================================================
  // command sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      seq_active_reg <= 1'b0;
      expect_reg <= 16'h0000;
      seg_end_reg <= 16'h0000;
      last_seg_reg <= 1'b0;
      words_left_reg <= 23'h000000;
      err_reg <= ERR_RESET;
      cond_reg <= COND_RESET;
      link.done <= 1'b0;
      link.data_ready <= 1'b0;
      img_we <= 1'b0;
      img_addr <= 23'h000000;
      img_data <= 32'h00000000;
      discard <= 1'b0;
      commit <= 1'b0;
      spin_down <= 1'b0;
      other_cmd <= 1'b0;
      other_opcode <= 8'h00;
    end
    else
    begin
      // pulses default low
      link.done <= 1'b0;
      img_we <= 1'b0;
      discard <= 1'b0;
      commit <= 1'b0;
      spin_down <= 1'b0;
      other_cmd <= 1'b0;
      if (link.soft_reset)
      begin
        // reset wins over anything in flight
        state_reg <= ST_IDLE;
        seq_active_reg <= 1'b0;
        discard <= seq_active_reg || state_reg != ST_IDLE;
        link.data_ready <= 1'b0;
        err_reg <= ERR_RESET;
        cond_reg <= COND_RESET;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (take && !is_dl)
            begin
              // hand off for normal execution and drop any partial image
              other_cmd <= 1'b1;
              other_opcode <= link.cmd_opcode;
              discard <= seq_active_reg;
              seq_active_reg <= 1'b0;
              err_reg <= 8'h00;
              cond_reg <= finish(8'h00);
              link.done <= 1'b1;
            end
            else if (take && (!sub_ok || security_locked))
            begin
              err_reg <= 8'h04;
              cond_reg <= finish(8'h04);
              link.done <= 1'b1;
            end
            else if (take && seg_mode && req_ofs != want_ofs)
            begin
              err_reg <= 8'h04;
              cond_reg <= finish(8'h04);
              discard <= 1'b1;
              seq_active_reg <= 1'b0;
              link.done <= 1'b1;
            end
            else if (take)
            begin
              // a single-shot load is always the last piece
              seg_end_reg <= seg_mode ? req_ofs + req_len : req_len;
              last_seg_reg <= !seg_mode ||
                ({1'b0, req_ofs} + {1'b0, req_len} >= {1'b0, image_sectors});
              img_addr <= seg_mode ? to_words(req_ofs) : 23'h000000;
              words_left_reg <= to_words(req_len);
              err_reg <= 8'h00;
              cond_reg <= 8'h00;
              cond_reg[ST_BSY] <= 1'b1;
              if (!seg_mode)
                seq_active_reg <= 1'b0;
              if (req_len == 16'h0000)
              begin
                // nothing to move: close the command at once
                cond_reg <= finish(8'h00);
                link.done <= 1'b1;
              end
              else
              begin
                state_reg <= ST_XFER;
                link.data_ready <= 1'b1;
                cond_reg[ST_DRQ] <= 1'b1;
              end
            end
          end
          ST_XFER:
          begin
            if (img_we)
              img_addr <= img_addr + 23'h000001;
            if (beat)
            begin
              // whole sectors only, so words_left ends exactly at one
              img_we <= 1'b1;
              img_data <= link.data;
              words_left_reg <= words_left_reg - 23'h000001;
              if (words_left_reg == 23'h000001)
              begin
                link.data_ready <= 1'b0;
                cond_reg[ST_DRQ] <= 1'b0;
                if (last_seg_reg)
                begin
                  state_reg <= ST_COMMIT;
                  commit <= 1'b1;
                  seq_active_reg <= 1'b0;
                end
                else
                begin
                  state_reg <= ST_IDLE;
                  seq_active_reg <= 1'b1;
                  expect_reg <= seg_end_reg;
                  cond_reg <= finish(8'h00);
                  link.done <= 1'b1;
                end
              end
            end
          end
          ST_COMMIT:
          begin
            if (commit_done)
            begin
              state_reg <= ST_IDLE;
              // a reload that was asked for and failed is uncorrectable
              err_reg[ERR_UNC] <= reload_req && !reload_ok;
              cond_reg <= finish({1'b0, reload_req && !reload_ok,
                6'h00});
              spin_down <= reload_req && spinup_disabled;
              link.done <= 1'b1;
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
            link.data_ready <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : mcd_device
`default_nettype wire

//--- verif/mcd_assertions.sv
// concurrent checks on the task-file link between host and drive ends
`timescale 1ns/1ps
`default_nettype none
module mcd_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic soft_reset,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic done,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] condition_flags
);
  import mcd_pkg::*;
  // ===========================================================
  // link properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic is_dl;
  logic sub_ok;
  logic idle;
  // commands count only when the drive is not busy, others are ignored
  assign is_dl = cmd_valid && cmd_opcode == OPC_DOWNLOAD;
  assign sub_ok = cmd_feature == SUB_OFFSETS || cmd_feature == SUB_SINGLE;
  assign idle = !condition_flags[ST_BSY];
  a_bad_sub_abort:
    assert property (is_dl && !sub_ok && idle
      |-> ##1 done && error_flags[ERR_ABT] && condition_flags[ST_ERR])
    else $error("reserved subcommand not aborted");
  a_dl_accept:
    assert property (is_dl && sub_ok && idle |-> ##1 (data_ready || done))
    else $error("download command not taken");
  a_other_exec:
    assert property (cmd_valid && cmd_opcode != OPC_DOWNLOAD && idle
      |-> ##[1:2] (done && condition_flags == 8'h50 && error_flags == 8'h00))
    else $error("other command not completed cleanly");
  a_done_status:
    assert property (done |-> !condition_flags[ST_BSY]
      && condition_flags[ST_RDY] && condition_flags[ST_DSC]
      && !condition_flags[ST_DF] && !condition_flags[ST_DRQ]
      && (condition_flags[ST_ERR] == (error_flags[ERR_UNC]
      || error_flags[ERR_ABT])))
    else $error("completion status wrong");
  a_err_unused:
    assert property ((error_flags & 8'hbb) == 8'h00)
    else $error("unused error bit set");
  a_done_pulse:
    assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_xfer_busy:
    assert property (data_ready |-> condition_flags[ST_BSY]
      && condition_flags[ST_DRQ])
    else $error("transfer phase without busy and request");
  a_soft_reset_drop:
    assert property (soft_reset |=> !data_ready)
    else $error("transfer survives soft reset");
  a_ready_holds:
    assert property (data_ready && !data_valid && !soft_reset |=> data_ready)
    else $error("transfer phase ended without data");
endmodule : mcd_assertions
`default_nettype wire

//--- verif/tb_microcode_download_handler.sv
// self-checking bench: host and drive ends joined over the task-file link
`timescale 1ns/1ps
`default_nettype none
module tb_microcode_download_handler;
  import mcd_pkg::*;
  // ===========================================================
  // signals
  typedef struct {
    logic [7:0] op;
    logic [7:0] feat;
    logic [7:0] err;
    logic [7:0] cond;
  } mcd_row_t;
  mcd_row_t rows [9] = '{'{8'h92, 8'h00, 8'h04, 8'h51},
    '{8'h92, 8'h01, 8'h04, 8'h51}, '{8'h92, 8'h06, 8'h04, 8'h51},
    '{8'h92, 8'h08, 8'h04, 8'h51}, '{8'h92, 8'h13, 8'h04, 8'h51},
    '{8'h92, 8'hff, 8'h04, 8'h51}, '{8'h90, 8'h03, 8'h00, 8'h50},
    '{8'h93, 8'h07, 8'h00, 8'h50}, '{8'h12, 8'h00, 8'h00, 8'h50}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, rd, img_data, last_data;
  logic locked = 1'b0, spin_off = 1'b0, rl_req = 1'b0, rl_ok = 1'b1;
  logic [15:0] img_secs = 16'h0002;
  logic commit_done = 1'b0;
  logic [2:0] cpipe = 3'b000;
  logic img_we, discard, commit, spin_down, other_cmd;
  logic [22:0] img_addr, last_addr;
  logic [7:0] other_opcode;
  int n_fail = 0, checks_done = 0;
  int n_we = 0, n_disc = 0, n_com = 0, n_spin = 0, n_oth = 0;
  always #2 aclk = ~aclk;
  // ===========================================================
  // the two ends and the link checker
  mcd_if i_mcd_if ();
  mcd_device i_mcd_device (.aclk(aclk), .aresetn(aresetn), .link(i_mcd_if),
    .security_locked(locked), .spinup_disabled(spin_off),
    .image_sectors(img_secs), .img_we(img_we), .img_addr(img_addr),
    .img_data(img_data), .discard(discard), .commit(commit),
    .commit_done(commit_done), .reload_req(rl_req), .reload_ok(rl_ok),
    .spin_down(spin_down), .other_cmd(other_cmd),
    .other_opcode(other_opcode));
  mcd_host i_mcd_host (.aclk(aclk), .aresetn(aresetn), .link(i_mcd_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  mcd_assertions i_mcd_assertions (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(i_mcd_if.cmd_valid), .cmd_opcode(i_mcd_if.cmd_opcode),
    .cmd_feature(i_mcd_if.cmd_feature), .soft_reset(i_mcd_if.soft_reset),
    .data_valid(i_mcd_if.data_valid), .data_ready(i_mcd_if.data_ready),
    .done(i_mcd_if.done), .error_flags(i_mcd_if.error_flags),
    .condition_flags(i_mcd_if.condition_flags));
  // save and reload answer a few cycles after each commit
  always @(posedge aclk)
  begin
    cpipe <= {cpipe[1:0], commit === 1'b1};
    commit_done <= cpipe[2];
  end
  // image writes and side pulses counted as they happen
  always @(posedge aclk)
  begin
    if (img_we === 1'b1)
    begin
      n_we++;
      last_addr = img_addr;
      last_data = img_data;
    end
    if (discard === 1'b1) n_disc++;
    if (commit === 1'b1) n_com++;
    if (spin_down === 1'b1) n_spin++;
    if (other_cmd === 1'b1) n_oth++;
  end
  // ===========================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // valids held until their own ready, bready until bvalid is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic issue(input logic [7:0] op, input logic [7:0] feat,
    input logic [15:0] len, input logic [15:0] ofs);
    axi_wr(OFS_TASK, {len[15:8], len[7:0], feat, op}, r);
    axi_wr(OFS_OFFSET, {16'h0000, ofs}, r);
    axi_wr(OFS_CTRL, 32'h0000_0001, r);
  endtask : issue
  task automatic push(input logic [15:0] ofs);
    for (int i = 0; i < SECTOR_WORDS; i++)
      axi_wr(OFS_DATA, {ofs, 16'(i)}, r);
  endtask : push
  task automatic finish_cmd(input logic [7:0] err, input logic [7:0] cond);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 5000)
    begin
      @(posedge aclk);
      i++;
    end
    check("irq raised", irq, 1'b1);
    axi_rd(OFS_IRQ_STAT, rd, r);
    check("irq status", rd[1:0], {err != 8'h00, 1'b1});
    axi_rd(OFS_RESULT, rd, r);
    check("result", rd[16:0], {1'b0, cond, err});
    repeat (3) @(posedge aclk);
    check("irq cleared", irq, 1'b0);
  endtask : finish_cmd
  task automatic seg(input logic [15:0] ofs, input logic [7:0] err,
    input logic [7:0] cond);
    issue(OPC_DOWNLOAD, SUB_OFFSETS, 16'h0001, ofs);
    if (err == 8'h00) push(ofs);
    finish_cmd(err, cond);
  endtask : seg
  // ===========================================================
  // hang guard, then the main sequence
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check("cond reset", i_mcd_if.condition_flags, COND_RESET);
    check("err reset", i_mcd_if.error_flags, ERR_RESET);
    axi_rd(OFS_RESULT, rd, r);
    check("result reset", rd[16:0], {1'b0, COND_RESET, ERR_RESET});
    axi_rd(8'h40, rd, r);
    check("unmapped rresp", r, RESP_SLVERR);
    axi_wr(8'h44, 32'h1, r);
    check("unmapped bresp", r, RESP_SLVERR);
    axi_wr(OFS_IRQ_MASK, 32'h3, r);
    axi_rd(OFS_IRQ_MASK, rd, r);
    check("mask", rd[1:0], 2'b11);
    // reserved subcommands and non-download commands, one per row
    foreach (rows[k])
    begin
      issue(rows[k].op, rows[k].feat, 16'h0001, 16'h0000);
      finish_cmd(rows[k].err, rows[k].cond);
      if (rows[k].op != OPC_DOWNLOAD)
        check("other opcode", other_opcode, rows[k].op);
    end
    check("no image writes", n_we, 0);
    // two segments, the second one last: save, reload and spin down
    spin_off <= 1'b1;
    rl_req <= 1'b1;
    seg(16'h0000, 8'h00, 8'h50);
    check("seg0 words", n_we, 128);
    check("seg0 addr", last_addr, 23'h7f);
    check("seg0 no commit", n_com, 0);
    seg(16'h0001, 8'h00, 8'h50);
    check("seg1 addr", last_addr, 23'hff);
    check("seg1 data", last_data, 32'h0001_007f);
    check("commit", n_com, 1);
    check("spin down", n_spin, 1);
    // gap in offsets
    seg(16'h0000, 8'h00, 8'h50);
    seg(16'h0002, 8'h04, 8'h51);
    check("gap discard", n_disc, 1);
    // another command in mid-sequence
    seg(16'h0000, 8'h00, 8'h50);
    issue(8'he5, 8'h00, 16'h0000, 16'h0000);
    finish_cmd(8'h00, 8'h50);
    check("other discard", n_disc, 2);
    check("other opcode e5", other_opcode, 8'he5);
    // soft reset in mid-sequence, then a restart not at zero
    seg(16'h0000, 8'h00, 8'h50);
    axi_wr(OFS_CTRL, 32'h2, r);
    repeat (4) @(posedge aclk);
    check("reset discard", n_disc, 3);
    axi_rd(OFS_IRQ_STAT, rd, r);
    seg(16'h0001, 8'h04, 8'h51);
    // locked drive refuses
    locked <= 1'b1;
    issue(OPC_DOWNLOAD, SUB_SINGLE, 16'h0001, 16'h0000);
    finish_cmd(8'h04, 8'h51);
    locked <= 1'b0;
    // zero length completes at once
    issue(OPC_DOWNLOAD, SUB_SINGLE, 16'h0000, 16'h0000);
    finish_cmd(8'h00, 8'h50);
    // single shot ignores the offset; the reload fails
    rl_ok <= 1'b0;
    spin_off <= 1'b0;
    issue(OPC_DOWNLOAD, SUB_SINGLE, 16'h0001, 16'h0005);
    push(16'h0005);
    finish_cmd(8'h40, 8'h51);
    check("single addr", last_addr, 23'h7f);
    check("single commit", n_com, 2);
    check("no spin", n_spin, 1);
    // masked completion leaves irq low but status set
    axi_wr(OFS_IRQ_MASK, 32'h0, r);
    issue(8'h90, 8'h00, 16'h0000, 16'h0000);
    repeat (20) @(posedge aclk);
    check("masked irq", irq, 1'b0);
    axi_rd(OFS_IRQ_STAT, rd, r);
    check("masked stat", rd[1:0], 2'b01);
    check("other cmds", n_oth, 5);
    tally_and_finish();
  end
endmodule : tb_microcode_download_handler
`default_nettype wire
